// ==== verilog/pms_pkg.sv ====
// Constants for the power and module transition sequencer.
// Assumes a single 125 MHz always-on clock and a byte-addressed AHB-Lite register window.
package pms_pkg;
	localparam int NUM_DOM = 5;             // Power domains, 0 is permanent
	localparam int NUM_MOD = 11;            // Gated modules
	localparam int ADDR_W  = 12;            // Register window address bits

	// Register byte offsets
	localparam logic [11:0] PID_OFS                    = 12'h000;
	localparam logic [11:0] TRANSITION_COMMAND_REG_OFS = 12'h120;
	localparam logic [11:0] TRANSITION_STATUS_REG_OFS  = 12'h128;
	localparam logic [11:0] PDSTAT_BASE                = 12'h200;
	localparam logic [11:0] DOMAIN_CONTROL_REG_BASE    = 12'h300;
	localparam logic [11:0] MDSTAT_BASE                = 12'h800;
	localparam logic [11:0] MODULE_CONTROL_REG_BASE    = 12'ha00;

	// Identification word, value is arbitrary
	localparam logic [31:0] PID_VALUE = 32'h00a5_0100;

	// Field positions and encodings
	localparam int          PD_NEXT_BIT  = 0;
	localparam logic        PD_NEXT_ON   = 1'b1;
	localparam int          MD_NEXT_LSB  = 0;
	localparam logic [2:0]  MD_NEXT_EN   = 3'h3;
	localparam logic [2:0]  MD_NEXT_DIS  = 3'h0;
	localparam int          CORE_LOCAL_RESET_N_BIT = 8;
	localparam int          MD_BUSY_BIT  = 11;
	localparam int          MD_CLK_BIT   = 12;

	// Reset values
	localparam logic [4:0]  PD_NEXT_RST  = 5'h01;
	localparam logic [4:0]  PD_ON_RST    = 5'h01;
	localparam logic        CORE_LOCAL_RESET_N_RST = 1'b1;

	// Special modules
	localparam int RSV_MOD    = 0;
	localparam int CORE_MOD   = 1;
	localparam int SHARED_MOD = 5;

	// Memory wake time, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int WAKE_TIME_NS  = 200;
	localparam int WAKE_CYC      = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CNT_W    = 5;

	// Power domain that holds a module's memories
	function automatic logic [2:0] mod_domain(input int m);
		case (m)
			7:       mod_domain = 3'h1;
			8:       mod_domain = 3'h2;
			9:       mod_domain = 3'h3;
			10:      mod_domain = 3'h4;
			default: mod_domain = 3'h0;
		endcase
	endfunction : mod_domain

	// Modules that software may not move
	function automatic logic mod_fixed(input int m);
		mod_fixed = (m == RSV_MOD) || (m == CORE_MOD) || (m == SHARED_MOD);
	endfunction : mod_fixed
endpackage : pms_pkg

// ==== verilog/pms_module_seq.sv ====
// Per-module clock and reset sequencer.
// Assumes go_i is a one-cycle pulse and mem_awake_i is a level from the same clock.
`timescale 1ns/10ps
module pms_module_seq #(
	parameter bit ALWAYS_ON = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	input  wire logic want_en_i,
	input  wire logic force_i,
	input  wire logic mem_awake_i,
	output logic      clk_en_o,
	output logic      rst_n_o,
	output logic      busy_o
);
	typedef enum logic [1:0] {DISABLED, WAIT_MEM, CLK_ON, ENABLED} pms_mod_e;
	pms_mod_e state;
	pms_mod_e next_state;

	// Enable only: memory first, then clock, then reset release
	always_comb begin
		next_state = state;
		unique case (state)
			DISABLED: if ((go_i && want_en_i) || force_i) next_state = WAIT_MEM;
			WAIT_MEM: if (mem_awake_i) next_state = CLK_ON;
			CLK_ON:   next_state = ENABLED;
			ENABLED:  next_state = ENABLED;
		endcase
	end

	// State and registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= ALWAYS_ON ? ENABLED : DISABLED;
			clk_en_o <= ALWAYS_ON;
			rst_n_o  <= ALWAYS_ON;
			busy_o   <= 1'b0;
		end else begin
			state    <= next_state;
			clk_en_o <= (next_state == CLK_ON) || (next_state == ENABLED);
			rst_n_o  <= (next_state == ENABLED);
			busy_o   <= (next_state == WAIT_MEM) || (next_state == CLK_ON);
		end
	end

	clk_before_rst_a : assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(rst_n_o) |-> $past(clk_en_o) && $past(mem_awake_i, 2))
		else $error("Reset released before clock or memory");

	enable_is_final_a : assert property (@(posedge clk_i) disable iff (rst_i)
		rst_n_o |=> rst_n_o && clk_en_o)
		else $error("Enabled module left the Enable state");
endmodule : pms_module_seq

// ==== verilog/pms_sequencer.sv ====
// Power domain and module transition sequencer with an AHB-Lite register slave.
// Assumes one always-on 125 MHz clock, word-only single transfers, async emulation inputs.
// Summary of operation
// - Domain 0 is permanently on and is never taken off.
// - Domains 1 to 4 leave reset off with memories asleep.
// - An on domain never goes back off; writes asking so are ignored.
// - Domain next field value one requests power on.
// - A go bit evaluates the domain next field and its modules together.
// - Module next field value three requests Enable.
// - Status bit stays set until domain and modules finish, then clears.
// - An enabled module never leaves Enable.
// - Memory wakes first, then module clock starts, then reset releases.
// - A combined go still wakes memory before the module is enabled.
// - Going on, the domain wakes its memories with no further software action.
// - Core clock domain ignores software transition commands.
// - Emulation force power turns the selected domain on.
// - Emulation force active turns the domain on and enables the module, except reserved module 0, which it does not enable.
// - Emulation assert reset asserts the core local reset.
// - Emulation wait reset holds local reset until the command ends.
// - Emulation block reset ignores software local and module reset assertion.
// - Only the core has a local reset.
// - Enable means reset released and clock on; disabled means the reverse.
// - Five go bits, one per domain, start evaluation when written one.
// - Status bit is one while the domain or any of its modules moves.
// - Local reset field zero asserts, one releases; memories stay reachable.
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module pms_sequencer (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	input  wire logic        HSEL_I,
	input  wire logic [11:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	input  wire logic [4:0]  EMU_FORCE_POWER_I,
	input  wire logic [10:0] EMU_FORCE_ACTIVE_I,
	input  wire logic        EMU_ASSERT_RESET_I,
	input  wire logic        EMU_WAIT_RESET_I,
	input  wire logic        EMU_BLOCK_RESET_I,
	output logic      [4:0]  MEM_SLEEP_O,
	output logic      [10:0] MOD_CLK_EN_O,
	output logic      [10:0] MOD_RST_N_O,
	output logic             CORE_LOCAL_RESET_N_O
);
	localparam int ND = pms_pkg::NUM_DOM;
	localparam int NM = pms_pkg::NUM_MOD;
	localparam int EW = ND + NM + 3;

	// Bus slave state
	logic                      rd_pend;
	logic                      wr_pend;
	logic [11:0]               rd_addr;
	logic [11:0]               wr_addr;
	logic [31:0]               rd_word;
	logic                      accept;

	// Software registers
	logic [ND-1:0]             pd_next;
	logic [2:0]                md_next [NM];
	logic                      core_local_reset_n;
	logic [ND-1:0]             go_pulse;

	// Sequencer state
	logic [ND-1:0]             pd_on;
	logic [ND-1:0]             waking;
	logic [pms_pkg::WAKE_CNT_W-1:0] wake_cnt [ND];
	logic [ND-1:0]             wake_req;
	logic [ND-1:0]             dom_mod_busy;
	logic [ND-1:0]             status;
	logic [NM-1:0]             mod_busy;
	logic [NM-1:0]             want_en;

	// Emulation synchronisers
	logic [EW-1:0]             emu_meta;
	logic [EW-1:0]             emu_sync;
	logic [ND-1:0]             emu_force_pwr;
	logic [NM-1:0]             emu_force_act;
	logic                      emu_assert;
	logic                      emu_wait;
	logic                      emu_block;

	// Two-flop synchroniser for all emulation inputs
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			emu_meta <= '0;
			emu_sync <= '0;
		end else begin
			emu_meta <= {EMU_FORCE_POWER_I, EMU_FORCE_ACTIVE_I, EMU_ASSERT_RESET_I,
				EMU_WAIT_RESET_I, EMU_BLOCK_RESET_I};
			emu_sync <= emu_meta;
		end
	end

	assign emu_force_pwr = emu_sync[EW-1 -: ND];
	assign emu_force_act = emu_sync[NM+2:3];
	assign emu_assert    = emu_sync[2];
	assign emu_wait      = emu_sync[1];
	assign emu_block     = emu_sync[0];

	// Address phase taken when selected, non-idle and bus ready
	assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;

	// Bus handshake: writes zero wait, reads one wait state
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			rd_pend     <= 1'b0;
			wr_pend     <= 1'b0;
			rd_addr     <= '0;
			wr_addr     <= '0;
			HRDATA_O    <= '0;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			wr_pend <= accept && HWRITE_I;
			rd_pend <= accept && !HWRITE_I;
			if (accept && HWRITE_I) begin
				wr_addr <= HADDR_I;
			end
			if (accept && !HWRITE_I) begin
				rd_addr     <= HADDR_I;
				HREADYOUT_O <= 1'b0;
			end else if (rd_pend) begin
				HRDATA_O    <= rd_word;
				HREADYOUT_O <= 1'b1;
			end
		end
	end

	// Read multiplexer; unmapped words read zero
	always_comb begin
		rd_word = '0;
		if (rd_addr == pms_pkg::PID_OFS) begin
			rd_word = pms_pkg::PID_VALUE;
		end
		if (rd_addr == pms_pkg::TRANSITION_STATUS_REG_OFS) begin
			rd_word[ND-1:0] = status;
		end
		for (int i = 0; i < ND; i++) begin
			if (rd_addr == 12'(pms_pkg::PDSTAT_BASE + 4 * i)) begin
				rd_word[0] = pd_on[i];
			end
			if (rd_addr == 12'(pms_pkg::DOMAIN_CONTROL_REG_BASE + 4 * i)) begin
				rd_word[pms_pkg::PD_NEXT_BIT] = pd_next[i];
			end
		end
		for (int m = 0; m < NM; m++) begin
			if (rd_addr == 12'(pms_pkg::MDSTAT_BASE + 4 * m)) begin
				rd_word[2:0] = MOD_RST_N_O[m] ? pms_pkg::MD_NEXT_EN : pms_pkg::MD_NEXT_DIS;
				rd_word[pms_pkg::MD_BUSY_BIT] = mod_busy[m];
				rd_word[pms_pkg::MD_CLK_BIT]  = MOD_CLK_EN_O[m];
				if (m == pms_pkg::CORE_MOD) begin
					rd_word[pms_pkg::CORE_LOCAL_RESET_N_BIT] = CORE_LOCAL_RESET_N_O;
				end
			end
			if (rd_addr == 12'(pms_pkg::MODULE_CONTROL_REG_BASE + 4 * m)) begin
				rd_word[2:0] = md_next[m];
				if (m == pms_pkg::CORE_MOD) begin
					rd_word[pms_pkg::CORE_LOCAL_RESET_N_BIT] = core_local_reset_n;
				end
			end
		end
	end

	// Go command: pulse per written one, never stored
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			go_pulse <= '0;
		end else if (wr_pend && wr_addr == pms_pkg::TRANSITION_COMMAND_REG_OFS) begin
			go_pulse <= HWDATA_I[ND-1:0];
		end else begin
			go_pulse <= '0;
		end
	end

	// Domain next fields; domain 0 fixed on, an on domain ignores writes to next
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pd_next <= pms_pkg::PD_NEXT_RST;
		end else begin
			for (int i = 1; i < ND; i++) begin
				if (wr_pend && !pd_on[i]
					&& wr_addr == 12'(pms_pkg::DOMAIN_CONTROL_REG_BASE + 4 * i)) begin
					pd_next[i] <= HWDATA_I[pms_pkg::PD_NEXT_BIT];
				end
			end
		end
	end

	// Module next fields; fixed modules and enabled modules ignore writes
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			for (int m = 0; m < NM; m++) begin
				md_next[m] <= pms_pkg::mod_fixed(m) && m != pms_pkg::RSV_MOD ?
					pms_pkg::MD_NEXT_EN : pms_pkg::MD_NEXT_DIS;
			end
		end else begin
			for (int m = 0; m < NM; m++) begin
				if (wr_pend && wr_addr == 12'(pms_pkg::MODULE_CONTROL_REG_BASE + 4 * m)
					&& !pms_pkg::mod_fixed(m) && !MOD_RST_N_O[m]) begin
					md_next[m] <= HWDATA_I[2:0];
				end
			end
		end
	end

	// Core local reset control field
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			core_local_reset_n <= pms_pkg::CORE_LOCAL_RESET_N_RST;
		end else if (wr_pend
			&& wr_addr == 12'(pms_pkg::MODULE_CONTROL_REG_BASE + 4 * pms_pkg::CORE_MOD)) begin
			core_local_reset_n <= HWDATA_I[pms_pkg::CORE_LOCAL_RESET_N_BIT];
		end
	end

	// Core local reset: emulation assert, block and wait applied over software
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			CORE_LOCAL_RESET_N_O <= 1'b1;
		end else if (emu_assert) begin
			CORE_LOCAL_RESET_N_O <= 1'b0;
		end else if (!core_local_reset_n && !emu_block) begin
			CORE_LOCAL_RESET_N_O <= 1'b0;
		end else if (!(emu_wait && !CORE_LOCAL_RESET_N_O)) begin
			CORE_LOCAL_RESET_N_O <= 1'b1;
		end
	end

	// Wake requests per domain from go, force power and force active
	always_comb begin
		wake_req     = '0;
		dom_mod_busy = '0;
		for (int i = 1; i < ND; i++) begin
			wake_req[i] = (go_pulse[i] && pd_next[i] == pms_pkg::PD_NEXT_ON)
				|| emu_force_pwr[i];
		end
		for (int m = 0; m < NM; m++) begin
			if (emu_force_act[m]) begin
				wake_req[pms_pkg::mod_domain(m)] = 1'b1;
			end
			if (mod_busy[m]) begin
				dom_mod_busy[pms_pkg::mod_domain(m)] = 1'b1;
			end
		end
		wake_req[0] = 1'b0;
	end

	// Status: go still pending, domain waking, or any module moving
	assign status = go_pulse | waking | dom_mod_busy;

	// Domain power state and memory wake timing
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pd_on       <= pms_pkg::PD_ON_RST;
			waking      <= '0;
			MEM_SLEEP_O <= ~pms_pkg::PD_ON_RST;
			for (int i = 0; i < ND; i++) begin
				wake_cnt[i] <= '0;
			end
		end else begin
			for (int i = 1; i < ND; i++) begin
				if (waking[i]) begin
					if (wake_cnt[i] == pms_pkg::WAKE_CNT_W'(pms_pkg::WAKE_CYC - 1)) begin
						waking[i] <= 1'b0;
						pd_on[i]  <= 1'b1;
					end else begin
						wake_cnt[i] <= wake_cnt[i] + 1'b1;
					end
				end else if (wake_req[i] && !pd_on[i]) begin
					waking[i]      <= 1'b1;
					wake_cnt[i]    <= '0;
					MEM_SLEEP_O[i] <= 1'b0;
				end
			end
		end
	end

	// Software enable requests; fixed modules take no software command
	always_comb begin
		for (int m = 0; m < NM; m++) begin
			want_en[m] = !pms_pkg::mod_fixed(m) && md_next[m] == pms_pkg::MD_NEXT_EN;
		end
	end

	// One sequencer per module, waiting on its memory domain
	for (genvar m = 0; m < NM; m++) begin : g_mod
		pms_module_seq #(
			.ALWAYS_ON (m == pms_pkg::CORE_MOD || m == pms_pkg::SHARED_MOD)
		) u_seq (
			.clk_i       (CLK_SYS_I),
			.rst_i       (RST_I),
			.go_i        (go_pulse[pms_pkg::mod_domain(m)]),
			.want_en_i   (want_en[m]),
			.force_i     (emu_force_act[m] && m != pms_pkg::RSV_MOD),
			.mem_awake_i (pd_on[pms_pkg::mod_domain(m)] && !MEM_SLEEP_O[pms_pkg::mod_domain(m)]),
			.clk_en_o    (MOD_CLK_EN_O[m]),
			.rst_n_o     (MOD_RST_N_O[m]),
			.busy_o      (mod_busy[m])
		);
	end

	perm_domain_on_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		pd_on[0] && !MEM_SLEEP_O[0])
		else $error("Permanent domain not on");

	reset_domains_off_a : assert property (@(posedge CLK_SYS_I)
		$fell(RST_I) |-> pd_on[4:1] == 4'h0 && MEM_SLEEP_O[4:1] == 4'hf)
		else $error("Switchable domain not off after reset");

	domain_stays_on_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		($past(pd_on) & ~pd_on) == '0)
		else $error("Domain went from on to off");

	wake_before_on_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		$fell(MEM_SLEEP_O[1]) |-> !pd_on[1] ##25 pd_on[1])
		else $error("Domain 1 wake time wrong");

	go_sets_status_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_pend && wr_addr == pms_pkg::TRANSITION_COMMAND_REG_OFS && HWDATA_I[2])
			|=> status[2])
		else $error("Go did not raise status");

	go_reads_zero_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(rd_pend && rd_addr == pms_pkg::TRANSITION_COMMAND_REG_OFS) |=> HRDATA_O == 32'h0)
		else $error("Go command read back nonzero");

	emu_assert_rst_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		emu_assert |=> !CORE_LOCAL_RESET_N_O)
		else $error("Emulation assert left local reset released");

	emu_wait_hold_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(emu_wait && !CORE_LOCAL_RESET_N_O) |=> !CORE_LOCAL_RESET_N_O)
		else $error("Local reset released during wait");

	emu_block_rst_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(emu_block && !emu_assert && CORE_LOCAL_RESET_N_O) |=> CORE_LOCAL_RESET_N_O)
		else $error("Software reset not blocked");

	core_always_on_a : assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		MOD_CLK_EN_O[pms_pkg::CORE_MOD] && MOD_RST_N_O[pms_pkg::CORE_MOD])
		else $error("Core clock domain moved");
endmodule : pms_sequencer

// ==== test/pms_far_end.sv ====
// Far-side model: emulation command pod and gated-module order monitor.
// Assumes the sequencer outputs are registered on the same system clock.
`timescale 1ns/10ps
module pms_far_end (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [4:0]  mem_sleep_i,
	input  wire logic [10:0] clk_en_i,
	input  wire logic [10:0] rst_n_i,
	input  wire logic [18:0] cmd_i,
	output logic      [4:0]  emu_pwr_o,
	output logic      [10:0] emu_act_o,
	output logic      [2:0]  emu_rst_o,
	output logic             order_err_o
);
	logic [10:0] prev_clk;

	// Emulation pins change just after the edge, like a pod on the system clock
	always_ff @(posedge clk_i) begin
		emu_pwr_o <= cmd_i[4:0];
		emu_act_o <= cmd_i[15:5];
		emu_rst_o <= cmd_i[18:16];
	end

	// Flags a module running on sleeping memory or leaving reset without a settled clock
	always_ff @(posedge clk_i) begin
		prev_clk <= clk_en_i;
		if (rst_i) begin
			order_err_o <= 1'b0;
		end else begin
			for (int m = 7; m < 11; m++) begin
				if (clk_en_i[m] && mem_sleep_i[m - 6]) order_err_o <= 1'b1;
			end
			for (int m = 0; m < 11; m++) begin
				if (rst_n_i[m] && !(clk_en_i[m] && prev_clk[m])) order_err_o <= 1'b1;
			end
		end
	end
endmodule : pms_far_end

// ==== test/tb_top.sv ====
// Self-checking bench for the power and module transition sequencer.
// Assumes the sequencer is the only slave on the bus and HREADY loops back.
`timescale 1ns/10ps
module tb_top;
	logic        clk;
	logic        rst;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [4:0]  mem_sleep;
	logic [10:0] clk_en;
	logic [10:0] rst_n;
	logic        core_rst_n;
	logic [4:0]  emu_pwr;
	logic [10:0] emu_act;
	logic [2:0]  emu_rst;
	logic [18:0] cmd;
	logic        order_err;
	logic [31:0] rd;
	logic [15:0] seed;
	int          err_total;
	int          checked;
	int          d;
	int          i;
	int          mods [4] = '{2, 3, 4, 6};

	pms_sequencer dut (
		.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.EMU_FORCE_POWER_I(emu_pwr), .EMU_FORCE_ACTIVE_I(emu_act),
		.EMU_ASSERT_RESET_I(emu_rst[0]), .EMU_WAIT_RESET_I(emu_rst[1]),
		.EMU_BLOCK_RESET_I(emu_rst[2]), .MEM_SLEEP_O(mem_sleep), .MOD_CLK_EN_O(clk_en),
		.MOD_RST_N_O(rst_n), .CORE_LOCAL_RESET_N_O(core_rst_n)
	);

	pms_far_end far (
		.clk_i(clk), .rst_i(rst), .mem_sleep_i(mem_sleep), .clk_en_i(clk_en),
		.rst_n_i(rst_n), .cmd_i(cmd), .emu_pwr_o(emu_pwr), .emu_act_o(emu_act),
		.emu_rst_o(emu_rst), .order_err_o(order_err)
	);

	// 125 MHz system clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [11:0] at(input logic [11:0] base, input int n);
		return base + 12'(4 * n);
	endfunction : at

	// Control register addresses of a module and of a domain
	function automatic logic [11:0] mod_ctl(input int n);
		return at(pms_pkg::MODULE_CONTROL_REG_BASE, n);
	endfunction : mod_ctl

	function automatic logic [11:0] dom_ctl(input int n);
		return at(pms_pkg::DOMAIN_CONTROL_REG_BASE, n);
	endfunction : dom_ctl

	// Expected clock enables after enabling the chosen domain-0 modules
	function automatic logic [10:0] exp_mask(input logic [3:0] sel);
		return 11'h022 | {4'h0, sel[3], 1'b0, sel[2:0], 2'h0};
	endfunction : exp_mask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: register %h, expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_pin(input logic [10:0] got, input logic [10:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: pins %h, expected %h", $time, got, exp);
		end
	endtask : chk_pin

	// One single word transfer; address held until ready, data held until ready
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wait_idle(input int dom);
		int n;
		n = 0;
		do begin
			bus(pms_pkg::TRANSITION_STATUS_REG_OFS, 1'b0, 32'h0);
			n++;
		end while (rd[dom] !== 1'b0 && n < 60);
		chk_word(rd & (32'h1 << dom), 32'h0);
	endtask : wait_idle

	task automatic core_step(input logic [31:0] v, input logic [2:0] e, input logic x);
		cmd[18:16] <= e;
		tick(4); // Emulation command settles through pod and synchroniser first
		bus(mod_ctl(1), 1'b1, v);
		tick(8);
		chk_pin({10'h0, core_rst_n}, {10'h0, x});
	endtask : core_step

	// Watchdog against a hung handshake
	initial begin
		tick(20000);
		err_total++;
		$display("wrong value at %0t: run timed out", $time);
		finish_test;
	end

	initial begin
		err_total = 0;
		checked = 0;
		seed = 16'h3023;
		rst = 1'b1;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		cmd = 19'h0;
		tick(4);
		rst <= 1'b0;
		tick(1);
		// Reset state
		chk_pin({6'h0, mem_sleep}, 11'h01e);
		chk_pin(clk_en, 11'h022);
		chk_pin(rst_n, 11'h022);
		bus(pms_pkg::PID_OFS, 1'b0, 32'h0);
		chk_word(rd, pms_pkg::PID_VALUE);
		for (d = 0; d < 5; d++) begin
			bus(at(pms_pkg::PDSTAT_BASE, d), 1'b0, 32'h0);
			chk_word(rd & 32'h1, (d == 0) ? 32'h1 : 32'h0);
		end
		// Unmapped place ignores random data
		seed = lfsr(seed);
		bus(12'h014, 1'b1, {seed, ~seed});
		bus(12'h014, 1'b0, 32'h0);
		chk_word(rd, 32'h0);
		// Random set of modules, a zero go first, then one go for all
		seed = lfsr(seed);
		for (i = 0; i < 4; i++) begin
			if (seed[i]) bus(mod_ctl(mods[i]), 1'b1, 32'h3);
		end
		bus(pms_pkg::TRANSITION_COMMAND_REG_OFS, 1'b1, 32'h0);
		chk_word({31'h0, hresp}, 32'h0);
		tick(40);
		chk_pin(clk_en, 11'h022);
		bus(pms_pkg::TRANSITION_COMMAND_REG_OFS, 1'b1, 32'h1);
		bus(pms_pkg::TRANSITION_COMMAND_REG_OFS, 1'b0, 32'h0);
		chk_word(rd, 32'h0);
		wait_idle(0);
		chk_pin(clk_en, exp_mask(seed[3:0]));
		chk_pin(rst_n, exp_mask(seed[3:0]));
		bus(at(pms_pkg::MDSTAT_BASE, mods[0]), 1'b0, 32'h0);
		chk_word(rd & 32'h7, seed[0] ? 32'h3 : 32'h0);
		// Disable requests on enabled modules and on the core, enable the rest
		for (i = 0; i < 4; i++) begin
			bus(mod_ctl(mods[i]), 1'b1, seed[i] ? 32'h0 : 32'h3);
		end
		bus(mod_ctl(1), 1'b1, 32'h100);
		bus(pms_pkg::TRANSITION_COMMAND_REG_OFS, 1'b1, 32'h1);
		wait_idle(0);
		chk_pin(clk_en, 11'h07e);
		// Combined domain power-up and module enable
		for (d = 1; d < 5; d++) begin
			bus(dom_ctl(d), 1'b1, 32'h1);
			bus(mod_ctl(d + 6), 1'b1, 32'h3);
			bus(pms_pkg::TRANSITION_COMMAND_REG_OFS, 1'b1, 32'h1 << d);
			bus(pms_pkg::TRANSITION_STATUS_REG_OFS, 1'b0, 32'h0);
			chk_word(rd, 32'h1 << d);
			wait_idle(d);
			chk_pin({10'h0, mem_sleep[d]}, 11'h0);
			chk_pin({10'h0, clk_en[d + 6] & rst_n[d + 6]}, 11'h1);
		end
		chk_pin({10'h0, order_err}, 11'h0);
		// Requests to turn domains off
		for (d = 0; d < 2; d++) begin
			bus(dom_ctl(d), 1'b1, 32'h0);
			bus(pms_pkg::TRANSITION_COMMAND_REG_OFS, 1'b1, 32'h1 << d);
			wait_idle(d);
			bus(at(pms_pkg::PDSTAT_BASE, d), 1'b0, 32'h0);
			chk_word(rd & 32'h1, 32'h1);
		end
		chk_pin({6'h0, mem_sleep}, 11'h0);
		// Core local reset under software and emulation control
		core_step(32'h0, 3'h0, 1'b0);
		core_step(32'h100, 3'h0, 1'b1);
		core_step(32'h0, 3'h4, 1'b1);
		core_step(32'h100, 3'h1, 1'b0);
		core_step(32'h100, 3'h0, 1'b1);
		core_step(32'h0, 3'h0, 1'b0);
		core_step(32'h100, 3'h2, 1'b0);
		core_step(32'h100, 3'h0, 1'b1);
		chk_pin(clk_en, 11'h7fe);
		// Second reset, then emulation forcing
		rst <= 1'b1;
		tick(4);
		rst <= 1'b0;
		tick(1);
		chk_pin({6'h0, mem_sleep}, 11'h01e);
		cmd[4:0] <= 5'h04;
		tick(40);
		chk_pin({6'h0, mem_sleep}, 11'h01a);
		cmd[14] <= 1'b1;
		tick(60);
		chk_pin({10'h0, clk_en[9] & rst_n[9]}, 11'h1);
		chk_pin({6'h0, mem_sleep}, 11'h012);
		chk_pin({10'h0, order_err}, 11'h0);
		finish_test;
	end
endmodule : tb_top
